// [core/wdnmi_device.sv]
// watchdog timer with key protection, prescaler and nmi/reset on compare match
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module wdnmi_device
    import wdnmi_pkg::*;
(
    input  wire logic pclk,       // apb and watchdog clock
    input  wire logic presetn,    // asynchronous active-low reset
    input  wire logic debug_mode, // cpu in debug mode, asynchronous
    input  wire logic [3:0] src_tick, // source oscillator ticks, one per source, same clock
    wdnmi_if.device   bus         // apb slave and request outputs
);
    import wdnmi_pkg::*;

    logic                   unlocked_reg;   // protection removed
    logic [1:0]             src_reg;        // counter_source_select
    logic [1:0]             div_reg;        // counter_divider_select
    logic                   dbg_run_reg;    // debug_keep_running
    wdnmi_mode_t            mode_reg;       // match_action_select
    logic                   stat_reg;       // interrupt_raised_status
    logic                   running_reg;    // run state
    logic [9:0]             cmp_reg;        // compare_value
    logic [9:0]             cnt_reg;        // the watchdog counter
    logic [WDNMI_PRE_W-1:0] pre_reg;        // prescaler
    logic [2:0]             dbg_sync_reg;   // debug input synchroniser
    logic                   dbg_reg;        // filtered debug level
    logic                   nmi_reg;        // nmi pulse
    logic                   rst_reg;        // reset pulse
    logic [31:0]            rdata_reg;      // read data

    logic wr_en;      // apb write access
    logic rd_en;      // apb read access
    logic prot_wr;    // protected write allowed
    logic clr_wr;     // counter clear strobe
    logic sel_tick;   // selected source pulse
    logic div_done;   // prescaler wrapped
    logic tick;       // counter operating tick
    logic match;      // compare match this tick
    logic [WDNMI_PRE_W-1:0] div_limit;

    // the slave answers in the first access cycle, no wait states
    assign bus.pready  = 1'b1;
    assign bus.pslverr = 1'b0;
    assign bus.prdata  = rdata_reg;
    assign bus.nmi_pulse   = nmi_reg;
    assign bus.reset_pulse = rst_reg;

    assign wr_en   = bus.psel && bus.penable && bus.pwrite;
    assign rd_en   = bus.psel && !bus.penable && !bus.pwrite;
    assign prot_wr = wr_en && unlocked_reg;
    assign clr_wr  = prot_wr && (bus.paddr == WDNMI_OFS_CTRL)
                     && bus.pwdata[WDNMI_CLR_BIT]; // writing zero is ignored

    // divide ratio per source and divider selection
    function automatic logic [WDNMI_PRE_W-1:0] ratio_m1(input logic [1:0] s, input logic [1:0] d);
        logic [WDNMI_PRE_W-1:0] r;
        r = 16'hffff;
        if (s == 2'h3)
            r = 16'h0000;  // external input, 1/1
        else if (s == 2'h1)
            r = 16'h007f;  // low-speed source, 1/128
        else
            case (d)
                2'h0: r = 16'h1fff;
                2'h1: r = 16'h3fff;
                2'h2: r = 16'h7fff;
                default: r = 16'hffff;
            endcase
        return r;
    endfunction

    assign div_limit = ratio_m1(src_reg, div_reg);
    assign sel_tick  = src_tick[src_reg];
    assign div_done  = sel_tick && (pre_reg == div_limit);
    // clock gated while frozen in debug
    assign tick      = div_done && running_reg && (dbg_run_reg || !dbg_reg);
    assign match     = tick && (cnt_reg == cmp_reg);

    // debug level through three flops; change accepted when last two agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dbg_sync_reg <= 3'h0;
            dbg_reg      <= 1'b0;
        end
        else
        begin
            dbg_sync_reg <= {dbg_sync_reg[1:0], debug_mode};
            if (dbg_sync_reg[2] == dbg_sync_reg[1])
                dbg_reg <= dbg_sync_reg[2];
        end
    end

    // key register: only the exact key unlocks, anything else relocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            unlocked_reg <= 1'b0;
        else if (wr_en && bus.paddr == WDNMI_OFS_PROTECT)
            unlocked_reg <= (bus.pwdata[15:0] == WDNMI_UNLOCK_KEY);
    end

    // protected configuration fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_reg     <= WDNMI_SRC_RST;
            div_reg     <= WDNMI_DIV_RST;
            dbg_run_reg <= 1'b0;
            mode_reg    <= WDNMI_MODE_RESET;
            running_reg <= 1'b0; // stopped after reset
            cmp_reg     <= WDNMI_CMP_RST;
        end
        else if (prot_wr)
        begin
            if (bus.paddr == WDNMI_OFS_CLKCFG)
            begin
                src_reg     <= bus.pwdata[WDNMI_CLK_SRC_LSB +: 2];
                div_reg     <= bus.pwdata[WDNMI_CLK_DIV_LSB +: 2];
                dbg_run_reg <= bus.pwdata[WDNMI_CLK_DBG_BIT];
            end
            else if (bus.paddr == WDNMI_OFS_CTRL)
            begin
                mode_reg    <= wdnmi_mode_t'(bus.pwdata[WDNMI_MODE_LSB +: 2]);
                running_reg <= (bus.pwdata[WDNMI_RUN_LSB +: 4] != WDNMI_RUN_STOP);
            end
            else if (bus.paddr == WDNMI_OFS_CMP)
                cmp_reg <= bus.pwdata[9:0];
        end
    end

    // prescaler; a frozen debug state also holds it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_reg <= '0;
        else if (clr_wr)
            pre_reg <= '0;
        else if (sel_tick && running_reg && (dbg_run_reg || !dbg_reg))
            pre_reg <= div_done ? '0 : pre_reg + WDNMI_PRE_W'(1);
    end

    // counter: clear wins, match wraps to zero, else counts up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 10'h000;
        else if (clr_wr)
            cnt_reg <= 10'h000;
        else if (match)
            cnt_reg <= 10'h000;
        else if (tick)
            cnt_reg <= cnt_reg + 10'h001;
    end

    // match actions; reserved mode issues nothing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_reg  <= 1'b0;
            rst_reg  <= 1'b0;
            stat_reg <= 1'b0;
        end
        else
        begin
            nmi_reg <= 1'b0; // pulses last one cycle
            rst_reg <= 1'b0;
            if (match && (mode_reg == WDNMI_MODE_RESET ||
                          (mode_reg == WDNMI_MODE_NMI_RESET && stat_reg)))
                rst_reg <= 1'b1;
            else if (match && (mode_reg == WDNMI_MODE_NMI ||
                               mode_reg == WDNMI_MODE_NMI_RESET))
                nmi_reg <= 1'b1;
            // a new nmi in the clear cycle wins over the clear
            if (match && !rst_reg && (mode_reg == WDNMI_MODE_NMI ||
                (mode_reg == WDNMI_MODE_NMI_RESET && !stat_reg)))
                stat_reg <= 1'b1;
            else if (clr_wr)
                stat_reg <= 1'b0;
        end
    end

    // read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_reg <= 32'h0000_0000;
        else if (rd_en)
        begin
            rdata_reg <= 32'h0000_0000;
            if (bus.paddr == WDNMI_OFS_PROTECT)
                rdata_reg[0] <= unlocked_reg;
            else if (bus.paddr == WDNMI_OFS_CLKCFG)
            begin
                rdata_reg[WDNMI_CLK_SRC_LSB +: 2] <= src_reg;
                rdata_reg[WDNMI_CLK_DIV_LSB +: 2] <= div_reg;
                rdata_reg[WDNMI_CLK_DBG_BIT]      <= dbg_run_reg;
            end
            else if (bus.paddr == WDNMI_OFS_CTRL)
            begin
                rdata_reg[WDNMI_RUN_LSB +: 4]  <= running_reg ? WDNMI_RUN_ACTIVE
                                                              : WDNMI_RUN_STOP;
                rdata_reg[WDNMI_STAT_BIT]      <= stat_reg;
                rdata_reg[WDNMI_MODE_LSB +: 2] <= mode_reg;
                // clear bit always reads zero
            end
            else if (bus.paddr == WDNMI_OFS_CMP)
                rdata_reg[9:0] <= cmp_reg;
        end
    end

endmodule

// [core/wdnmi_host.sv]
// cpu-side controller driving the watchdog registers over apb
`timescale 1ns/1ps
module wdnmi_host
    import wdnmi_pkg::*;
(
    input  wire logic        pclk,        // clock
    input  wire logic        presetn,     // asynchronous active-low reset
    input  wire logic        cmd_valid,   // command request
    input  wire wdnmi_pkg::wdnmi_cmd_t cmd, // command code
    input  wire logic [1:0]  cfg_src,     // source for config
    input  wire logic [1:0]  cfg_div,     // divider for config
    input  wire logic        cfg_dbg_run, // keep running in debug
    input  wire logic [1:0]  cfg_mode,    // match action
    input  wire logic [9:0]  cfg_cmp,     // compare value
    output logic             cmd_ready,   // idle, command accepted
    output logic             cmd_done,    // one-cycle pulse at end
    output logic             nmi_seen,    // sticky: nmi arrived
    output logic             reset_seen,  // sticky: reset request arrived
    wdnmi_if.host            bus          // apb master
);
    import wdnmi_pkg::*;

    typedef enum logic [2:0] {
        WDNMI_H_IDLE  = 3'b001,
        WDNMI_H_SETUP = 3'b010,
        WDNMI_H_ACC   = 3'b100
    } wdnmi_hst_t;

    wdnmi_hst_t   st_reg;
    wdnmi_cmd_t   cmd_reg;
    logic [2:0]   step_reg;   // index into the write sequence
    logic [7:0]   addr_reg;
    logic [31:0]  data_reg;
    logic [9:0]   cmp_reg;
    logic [8:0]   clk_word_reg;
    logic [1:0]   mode_reg;
    logic [2:0]   last_step;
    logic         seq_end;

    // write sequence: unlock, body, relock
    function automatic logic [39:0] step_word(input wdnmi_cmd_t c, input logic [2:0] s,
                                              input logic [8:0] ck, input logic [1:0] m,
                                              input logic [9:0] cp);
        logic [39:0] w;
        w = {WDNMI_OFS_PROTECT, 32'h0000_0000};
        if (s == 3'h0)
            w = {WDNMI_OFS_PROTECT, 16'h0000, WDNMI_UNLOCK_KEY};
        else if (c == WDNMI_CMD_CONFIG && s == 3'h1)
            w = {WDNMI_OFS_CLKCFG, 23'h0, ck};
        else if (c == WDNMI_CMD_CONFIG && s == 3'h2)
            w = {WDNMI_OFS_CTRL, 21'h0, m, 5'h00, WDNMI_RUN_STOP};
        else if (c == WDNMI_CMD_CONFIG && s == 3'h3)
            w = {WDNMI_OFS_CMP, 22'h0, cp};
        else if (c == WDNMI_CMD_START && s == 3'h1)
            w = {WDNMI_OFS_CTRL, 21'h0, m, 5'h01, WDNMI_RUN_STOP}; // clear first
        else if (c == WDNMI_CMD_START && s == 3'h2)
            w = {WDNMI_OFS_CTRL, 21'h0, m, 5'h00, 4'h5};           // run code
        else if (c == WDNMI_CMD_KICK && s == 3'h1)
            w = {WDNMI_OFS_CTRL, 21'h0, m, 5'h01, 4'h5};
        else if (c == WDNMI_CMD_STOP && s == 3'h1)
            w = {WDNMI_OFS_CTRL, 21'h0, m, 5'h00, WDNMI_RUN_STOP};
        return w;
    endfunction

    assign last_step = (cmd_reg == WDNMI_CMD_CONFIG) ? 3'h4 :
                       (cmd_reg == WDNMI_CMD_START)  ? 3'h3 : 3'h2;
    assign seq_end   = (st_reg == WDNMI_H_ACC) && bus.pready && (step_reg == last_step);
    assign cmd_ready = (st_reg == WDNMI_H_IDLE);
    assign bus.psel    = (st_reg != WDNMI_H_IDLE);
    assign bus.penable = (st_reg == WDNMI_H_ACC);
    assign bus.pwrite  = 1'b1;
    assign bus.paddr   = addr_reg;
    assign bus.pwdata  = data_reg;

    // sequencer state, command latch and step counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg       <= WDNMI_H_IDLE;
            cmd_reg      <= WDNMI_CMD_NONE;
            step_reg     <= 3'h0;
            cmp_reg      <= WDNMI_CMP_RST;
            clk_word_reg <= 9'h000;
            mode_reg     <= WDNMI_MODE_RST;
            addr_reg     <= 8'h00;
            data_reg     <= 32'h0000_0000;
            cmd_done     <= 1'b0;
        end
        else
        begin
            cmd_done <= 1'b0;
            case (st_reg)
                WDNMI_H_IDLE:
                begin
                    if (cmd_valid && cmd != WDNMI_CMD_NONE)
                    begin
                        cmd_reg  <= cmd;
                        step_reg <= 3'h0;
                        if (cmd == WDNMI_CMD_CONFIG)
                        begin
                            cmp_reg      <= cfg_cmp;
                            clk_word_reg <= {cfg_dbg_run, 2'h0, cfg_div, 2'h0, cfg_src};
                            mode_reg     <= cfg_mode;
                        end
                        {addr_reg, data_reg} <= {WDNMI_OFS_PROTECT, 16'h0000, WDNMI_UNLOCK_KEY};
                        st_reg <= WDNMI_H_SETUP;
                    end
                end
                WDNMI_H_SETUP:
                    st_reg <= WDNMI_H_ACC;
                WDNMI_H_ACC:
                begin
                    if (bus.pready)
                    begin
                        if (seq_end)
                        begin
                            st_reg   <= WDNMI_H_IDLE;
                            cmd_done <= 1'b1;
                        end
                        else
                        begin
                            step_reg <= step_reg + 3'h1;
                            {addr_reg, data_reg} <= step_word(cmd_reg, step_reg + 3'h1,
                                                               clk_word_reg, mode_reg, cmp_reg);
                            st_reg <= WDNMI_H_SETUP;
                        end
                    end
                end
                default:
                    st_reg <= WDNMI_H_IDLE;
            endcase
        end
    end

    // sticky capture of watchdog requests; nmi_seen is cleared by the next kick, reset_seen only by reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_seen   <= 1'b0;
            reset_seen <= 1'b0;
        end
        else
        begin
            if (bus.nmi_pulse)
                nmi_seen <= 1'b1;
            else if (seq_end && cmd_reg == WDNMI_CMD_KICK)
                nmi_seen <= 1'b0;
            if (bus.reset_pulse)
                reset_seen <= 1'b1;
        end
    end

endmodule

// [core/wdnmi_if.sv]
// interface joining the watchdog with the cpu-side apb master
`timescale 1ns/1ps
interface wdnmi_if;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        nmi_pulse;   // one-cycle interrupt request
    logic        reset_pulse; // one-cycle system reset request

    modport device
    (
        input  psel, penable, pwrite, paddr, pwdata,
        output prdata, pready, pslverr, nmi_pulse, reset_pulse
    );
    modport host
    (
        output psel, penable, pwrite, paddr, pwdata,
        input  prdata, pready, pslverr, nmi_pulse, reset_pulse
    );
endinterface

// [core/wdnmi_pkg.sv]
// package with register map, field positions, reset values and codes for the watchdog
package wdnmi_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0]  WDNMI_OFS_PROTECT = 8'h00; // system_protect_key
    localparam logic [7:0]  WDNMI_OFS_CLKCFG  = 8'h04; // watchdog_clock_config
    localparam logic [7:0]  WDNMI_OFS_CTRL    = 8'h08; // watchdog_control
    localparam logic [7:0]  WDNMI_OFS_CMP     = 8'h0c; // timeout_compare

    // protection key
    localparam logic [15:0] WDNMI_UNLOCK_KEY  = 16'h0096;

    // watchdog_clock_config field positions
    localparam int          WDNMI_CLK_SRC_LSB = 0;
    localparam int          WDNMI_CLK_DIV_LSB = 4;
    localparam int          WDNMI_CLK_DBG_BIT = 8;

    // watchdog_control field positions
    localparam int          WDNMI_RUN_LSB     = 0;
    localparam int          WDNMI_CLR_BIT     = 4;
    localparam int          WDNMI_STAT_BIT    = 8;
    localparam int          WDNMI_MODE_LSB    = 9;

    // run field codes
    localparam logic [3:0]  WDNMI_RUN_STOP    = 4'ha;
    localparam logic [3:0]  WDNMI_RUN_ACTIVE  = 4'h0;

    // reset values
    localparam logic [9:0]  WDNMI_CMP_RST     = 10'h3ff;
    localparam logic [1:0]  WDNMI_MODE_RST    = 2'h0;
    localparam logic [1:0]  WDNMI_SRC_RST     = 2'h0;
    localparam logic [1:0]  WDNMI_DIV_RST     = 2'h0;

    // prescaler width: largest documented ratio is 1/65,536
    localparam int          WDNMI_PRE_W       = 16;

    // operating modes of the match action field
    typedef enum logic [1:0] {
        WDNMI_MODE_RESET     = 2'h0,
        WDNMI_MODE_NMI       = 2'h1,
        WDNMI_MODE_NMI_RESET = 2'h2,
        WDNMI_MODE_RSVD      = 2'h3
    } wdnmi_mode_t;

    // host command codes
    typedef enum logic [2:0] {
        WDNMI_CMD_NONE   = 3'h0,
        WDNMI_CMD_CONFIG = 3'h1,
        WDNMI_CMD_START  = 3'h2,
        WDNMI_CMD_KICK   = 3'h3,
        WDNMI_CMD_STOP   = 3'h4
    } wdnmi_cmd_t;

endpackage

// [testbench/tb_top.sv]
// self-checking bench: host controller and watchdog joined by the link interface
`timescale 1ns/1ps
module tb_top;
    import wdnmi_pkg::*;
    logic        pclk;        // 20 MHz clock
    logic        presetn;     // active-low reset
    logic        debug_mode;  // cpu debug state
    logic [3:0]  src_tick;    // source ticks, every cycle
    logic        cmd_valid;   // command request
    wdnmi_cmd_t  cmd;         // command code
    logic [1:0]  cfg_src;     // source select
    logic [1:0]  cfg_div;     // divider select
    logic        cfg_dbg_run; // keep running in debug
    logic [1:0]  cfg_mode;    // match action
    logic [9:0]  cfg_cmp;     // compare value
    logic        cmd_ready;   // host idle
    logic        cmd_done;    // host finished
    logic        nmi_seen;    // sticky interrupt
    logic        reset_seen;  // sticky reset
    int          err_count;   // mismatches
    int          num_checks;  // comparisons
    int          cycles;      // timeout counter
    int          first_k[4];  // first request per mode: 0 none, 1 nmi, 2 reset
    int          second_k[4]; // second request per mode
    wdnmi_if link();

    wdnmi_device wdnmi_device_inst(.pclk(pclk), .presetn(presetn), .debug_mode(debug_mode),
        .src_tick(src_tick), .bus(link));
    wdnmi_host wdnmi_host_inst(.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid), .cmd(cmd),
        .cfg_src(cfg_src), .cfg_div(cfg_div), .cfg_dbg_run(cfg_dbg_run), .cfg_mode(cfg_mode),
        .cfg_cmp(cfg_cmp), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .nmi_seen(nmi_seen),
        .reset_seen(reset_seen), .bus(link));
    wdnmi_asserts wdnmi_asserts_inst(.pclk(pclk), .presetn(presetn), .psel(link.psel),
        .penable(link.penable), .pwrite(link.pwrite), .paddr(link.paddr), .pwdata(link.pwdata),
        .prdata(link.prdata), .pready(link.pready), .pslverr(link.pslverr),
        .nmi_pulse(link.nmi_pulse), .reset_pulse(link.reset_pulse));

    // 50 ns period
    always #25 pclk = ~pclk;

    // a hang counts as a mismatch; runs take about 30k cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    // one host command; edge reads see the cycle just ended
    task automatic do_cmd(input wdnmi_cmd_t c, input logic [1:0] m, input logic [9:0] cp,
                          input logic [1:0] s = 2'h3, input logic [1:0] d = 2'h0,
                          input logic g = 1'b0);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        cmd <= c;
        cfg_mode <= m;
        cfg_cmp <= cp;
        cfg_src <= s;
        cfg_div <= d;
        cfg_dbg_run <= g;
        cmd_valid <= 1'b1;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        n = 0;
        while (cmd_done !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        check(cmd_done, 1'b1, "command did not complete");
    endtask

    // waits up to hi cycles for a request; kind 0 none, 1 nmi, 2 reset
    task automatic expect_pulse(input int kind, input int lo, input int hi);
        int   n;
        logic hn;
        logic hr;
        n = 0;
        hn = 1'b0;
        hr = 1'b0;
        while (!hn && !hr && n < hi)
        begin
            @(posedge pclk);
            n++;
            hn = (link.nmi_pulse === 1'b1);
            hr = (link.reset_pulse === 1'b1);
        end
        check(hn, kind == 1, "interrupt request mismatch");
        check(hr, kind == 2, "reset request mismatch");
        if (kind != 0)
            check(n >= lo, 1'b1, "request came too early");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        debug_mode = 1'b0;
        src_tick = 4'hf;
        cmd_valid = 1'b0;
        cmd = WDNMI_CMD_NONE;
        {cfg_src, cfg_div, cfg_dbg_run, cfg_mode, cfg_cmp} = '0;
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        first_k = '{2, 1, 1, 0};
        second_k = '{2, 1, 2, 0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        expect_pulse(0, 0, 200);
        do_cmd(WDNMI_CMD_CONFIG, 2'h0, 10'h3ff);
        do_cmd(WDNMI_CMD_START, 2'h0, 10'h000);
        expect_pulse(2, 1016, 1032);
        @(posedge pclk);
        @(posedge pclk);
        check(reset_seen, 1'b1, "reset not reported");
        do_cmd(WDNMI_CMD_STOP, 2'h0, 10'h000);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(reset_seen, 1'b0, "sticky flag survived reset");
        // every mode code: first match, then exactly one period later
        for (int m = 0; m < 4; m++)
        begin
            do_cmd(WDNMI_CMD_CONFIG, m[1:0], 10'd20);
            do_cmd(WDNMI_CMD_START, m[1:0], 10'd20);
            expect_pulse(first_k[m], 13, 29);
            expect_pulse(second_k[m], 21, 21);
            do_cmd(WDNMI_CMD_KICK, m[1:0], 10'd20);
            do_cmd(WDNMI_CMD_STOP, m[1:0], 10'd20);
        end
        // a clear after the interrupt stops the escalation
        do_cmd(WDNMI_CMD_CONFIG, 2'h2, 10'd20);
        do_cmd(WDNMI_CMD_START, 2'h2, 10'd20);
        expect_pulse(1, 13, 29);
        do_cmd(WDNMI_CMD_KICK, 2'h2, 10'd20);
        expect_pulse(1, 13, 29);
        do_cmd(WDNMI_CMD_STOP, 2'h2, 10'd20);
        check(nmi_seen, 1'b1, "nmi flag lost");
        // periodic servicing keeps it quiet
        do_cmd(WDNMI_CMD_CONFIG, 2'h0, 10'd40);
        do_cmd(WDNMI_CMD_START, 2'h0, 10'd40);
        repeat (8)
        begin
            expect_pulse(0, 0, 25);
            do_cmd(WDNMI_CMD_KICK, 2'h0, 10'd40);
        end
        do_cmd(WDNMI_CMD_STOP, 2'h0, 10'd40);
        check(nmi_seen, 1'b0, "nmi flag kept after kick");
        // debug freeze, then keep-running
        for (int g = 0; g < 2; g++)
        begin
            do_cmd(WDNMI_CMD_CONFIG, 2'h1, 10'd20, 2'h3, 2'h0, g[0]);
            do_cmd(WDNMI_CMD_START, 2'h1, 10'd20);
            debug_mode <= 1'b1;
            expect_pulse(g, 13, 100);
            debug_mode <= 1'b0;
            if (g == 0)
                expect_pulse(1, 10, 32);
            do_cmd(WDNMI_CMD_KICK, 2'h1, 10'd20);
            do_cmd(WDNMI_CMD_STOP, 2'h1, 10'd20);
        end
        // divided sources: one tick every 128, 8192 and 16384 cycles
        do_cmd(WDNMI_CMD_CONFIG, 2'h1, 10'd3, 2'h1, 2'h0);
        do_cmd(WDNMI_CMD_START, 2'h1, 10'd3);
        expect_pulse(1, 496, 528);
        do_cmd(WDNMI_CMD_KICK, 2'h1, 10'd3);
        do_cmd(WDNMI_CMD_STOP, 2'h1, 10'd3);
        for (int d = 0; d < 2; d++)
        begin
            do_cmd(WDNMI_CMD_CONFIG, 2'h1, 10'd0, 2'h0, d[1:0]);
            do_cmd(WDNMI_CMD_START, 2'h1, 10'd0);
            expect_pulse(1, (8192 << d) - 16, (8192 << d) + 16);
            do_cmd(WDNMI_CMD_KICK, 2'h1, 10'd0);
            do_cmd(WDNMI_CMD_STOP, 2'h1, 10'd0);
        end
        tally_and_finish();
    end
endmodule

// [testbench/wdnmi_asserts.sv]
// concurrent checks on the apb link and the request pulses of the watchdog
`timescale 1ns/1ps
module wdnmi_asserts
    import wdnmi_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        nmi_pulse,
    input wire logic        reset_pulse
);
    import wdnmi_pkg::*;
    logic        wr_acc;    // write completing at this edge
    logic        ctrl_wr;   // write to the control word
    logic        any_req;   // either request pulse
    logic [9:0]  cmp_seen;  // last compare value written
    logic [1:0]  mode_seen; // last match action written
    logic        run_seen;  // last run code was not the stop code
    logic        nmi_since; // interrupt seen since the last counter clear
    logic        clean;     // no bus access since the previous pulse
    logic [11:0] gap;       // cycles since the previous pulse

    assign wr_acc  = psel && penable && pwrite && pready;
    assign ctrl_wr = wr_acc && (paddr == WDNMI_OFS_CTRL);
    assign any_req = nmi_pulse || reset_pulse;

    // shadow of the programmed fields; the host always unlocks first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_seen  <= WDNMI_CMP_RST;
            mode_seen <= WDNMI_MODE_RST;
            run_seen  <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            mode_seen <= pwdata[WDNMI_MODE_LSB +: 2];
            run_seen  <= (pwdata[3:0] != WDNMI_RUN_STOP);
        end
        else if (wr_acc && (paddr == WDNMI_OFS_CMP))
            cmp_seen  <= pwdata[9:0];
    end

    // pulse spacing and interrupt history; a new interrupt beats a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_since <= 1'b0;
            clean     <= 1'b0;
            gap       <= 12'h000;
        end
        else
        begin
            if (nmi_pulse)
                nmi_since <= 1'b1;
            else if (ctrl_wr && pwdata[WDNMI_CLR_BIT])
                nmi_since <= 1'b0;
            if (any_req)
                clean <= 1'b1;
            else if (psel)
                clean <= 1'b0;
            if (any_req)
                gap <= 12'h001;
            else if (gap != 12'hfff)
                gap <= gap + 12'h001;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    nmi_single_a: assert property (nmi_pulse |=> !nmi_pulse)
        else $error("interrupt request wider than one cycle");
    rst_single_a: assert property (reset_pulse |=> !reset_pulse)
        else $error("reset request wider than one cycle");
    one_action_a: assert property (!(nmi_pulse && reset_pulse))
        else $error("interrupt and reset requested together");
    match_period_a: assert property (any_req && clean |-> gap == {2'h0, cmp_seen} + 12'h001)
        else $error("match spacing differs from compare plus one");
    nmi_mode_a: assert property (nmi_pulse |-> mode_seen inside {2'h1, 2'h2})
        else $error("interrupt in a mode without interrupts");
    rst_mode_a: assert property (reset_pulse |-> mode_seen == 2'h0 || (mode_seen == 2'h2 && nmi_since))
        else $error("reset request without cause");
    stopped_quiet_a: assert property (any_req |-> $past(run_seen, 2))
        else $error("request while stopped");
    bus_answer_a: assert property (psel |-> pready && !pslverr)
        else $error("bus access not answered cleanly");

    nmi_c: cover property (nmi_pulse);
    rst_c: cover property (reset_pulse);
    escalate_c: cover property (reset_pulse && mode_seen == 2'h2);
endmodule
